// file: design/msp_device.sv
// device end: command receiver, error pin handling and error replies
`timescale 1ns/10ps
`default_nettype none
module msp_device
  import msp_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEF
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // link
  msp_link_if.dev          link,
  // settings port
  input  wire logic        cfgWr,
  input  wire logic [1:0]  cfgSel,
  input  wire logic [15:0] cfgData,
  // motion core
  input  wire logic [5:0]  coreErr,
  output logic             cmdStb,
  output logic [6:0]       cmdCode,
  output logic [6:0]       cmdArg,
  output logic             motorEn
);
  typedef enum logic [4:0] {
    P_IDLE = 5'b00001, P_NUM = 5'b00010, P_CMD = 5'b00100, P_ARG = 5'b01000,
    P_SKIP = 5'b10000
  } msp_pst_t;
  typedef struct packed {
    msp_pst_t    pst;
    logic [15:0] bitCyc;
    logic [6:0]  devNum;
    logic        ignErr;
    logic [6:0]  code;
    logic        eSync1;
    logic        eSync2;
    logic        extErr;
    logic        errOut;
    logic        motorEn;
    logic        cmdStb;
    logic [6:0]  cmdCode;
    logic [6:0]  cmdArg;
    logic        txGo;
    logic [7:0]  txByte;
  } msp_dev_t;
  msp_dev_t s_r, s_nxt;

  logic       hardRstN;
  logic       txBusy;
  logic       rxValid;
  logic [7:0] rxByte;
  logic       rxFrameErr;

  // ****************
  // hard reset from core reset or reset pin
  // ****************
  assign hardRstN = nrst & link.devRstN;

  // ****************
  // serial engine
  // ****************
  msp_uart u_uart (
    .core_clk   (core_clk),
    .nrst       (hardRstN),
    .bitCyc     (s_r.bitCyc),
    .txGo       (s_r.txGo),
    .txByte     (s_r.txByte),
    .txBusy     (txBusy),
    .txLine     (link.devTx),
    .rxPin      (link.hostTx),
    .rxValid    (rxValid),
    .rxByte     (rxByte),
    .rxFrameErr (rxFrameErr)
  );

  function automatic logic isCmd(input logic [7:0] b);
    isCmd = b[7] && (b != ADDR_PREFIX);
  endfunction : isCmd

  // ****************
  // next state
  // ****************
  always_comb begin
    s_nxt        = s_r;
    s_nxt.cmdStb = 1'b0;
    s_nxt.txGo   = 1'b0;
    // settings
    if (cfgWr) begin
      unique case (cfgSel)
        CFG_BAUD:   s_nxt.bitCyc = (cfgData == 16'h0000) ? 16'h0001 : cfgData;
        CFG_DEVNUM: s_nxt.devNum = cfgData[6:0];
        CFG_FLAGS:  s_nxt.ignErr = cfgData[FLAG_IGNERR];
        default:    s_nxt.ignErr = s_r.ignErr;
      endcase
    end
    // error line sensing and error output
    s_nxt.eSync1 = link.errLine;
    s_nxt.eSync2 = s_r.eSync1;
    s_nxt.extErr = s_r.eSync2 & ~s_r.ignErr;
    s_nxt.errOut = (|coreErr) | s_r.extErr;
    if (s_r.errOut) begin
      s_nxt.motorEn = 1'b0;
    end
    // command parser
    if (rxFrameErr) begin
      s_nxt.pst = P_IDLE;
    end else if (rxValid) begin
      if (rxByte == ADDR_PREFIX) begin
        s_nxt.pst = P_NUM;
      end else if (isCmd(rxByte)) begin
        s_nxt.code = rxByte[6:0];
        s_nxt.pst  = P_ARG;
      end else begin
        unique case (s_r.pst)
          P_IDLE: s_nxt.pst = P_IDLE;
          P_NUM:  s_nxt.pst = (rxByte[6:0] == s_r.devNum) ? P_CMD : P_SKIP;
          P_CMD: begin
            s_nxt.code = rxByte[6:0];
            s_nxt.pst  = P_ARG;
          end
          P_SKIP: s_nxt.pst = P_IDLE;
          P_ARG: begin
            s_nxt.pst     = P_IDLE;
            s_nxt.cmdStb  = 1'b1;
            s_nxt.cmdCode = s_r.code;
            s_nxt.cmdArg  = rxByte[6:0];
            if (s_r.code == CMD_ENERGIZE) begin
              s_nxt.motorEn = ~s_r.errOut;
            end
            if (s_r.code == CMD_DEENERGY) begin
              s_nxt.motorEn = 1'b0;
            end
            if (s_r.code == CMD_GET_ERR && !txBusy) begin
              s_nxt.txGo   = 1'b1;
              s_nxt.txByte = {s_r.errOut, s_r.extErr, coreErr};
            end
          end
          default: s_nxt.pst = P_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge hardRstN) begin
    if (!hardRstN) begin
      s_r <= '{pst: P_IDLE, bitCyc: 16'(BIT_CYC), devNum: DEVNUM_DEF, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************
  // outputs
  // ****************
  assign link.devErr = s_r.errOut;
  assign cmdStb      = s_r.cmdStb;
  assign cmdCode     = s_r.cmdCode;
  assign cmdArg      = s_r.cmdArg;
  assign motorEn     = s_r.motorEn;
endmodule : msp_device
`default_nettype wire

// file: design/msp_host.sv
// host end: register port to software, serial engine, quiet time after reset
`timescale 1ns/10ps
`default_nettype none
module msp_host
  import msp_pkg::*;
#(
  parameter int BIT_CYC   = BIT_CYC_DEF,
  parameter int QUIET_CYC = QUIET_CYC_DEF
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // interrupt
  output logic             irq,
  // link
  msp_link_if.host         link
);
  typedef struct packed {
    logic              devRst;
    logic [15:0]       bitCyc;
    logic [19:0]       quiet;
    logic              txGo;
    logic [7:0]        txByte;
    logic [7:0]        rxByte;
    logic              rxFull;
    logic              txBusyD;
    logic              eSync1;
    logic              eSync2;
    logic              ePrev;
    logic [IRQ_W-1:0]  iStat;
    logic [IRQ_W-1:0]  iMask;
    logic              irq;
    logic [31:0]       rdata;
  } msp_host_t;
  msp_host_t s_r, s_nxt;

  logic             txBusy;
  logic             rxValid;
  logic [7:0]       rxByte;
  logic             rxFrameErr;
  logic [IRQ_W-1:0] ev;

  msp_uart u_uart (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .bitCyc     (s_r.bitCyc),
    .txGo       (s_r.txGo),
    .txByte     (s_r.txByte),
    .txBusy     (txBusy),
    .txLine     (link.hostTx),
    .rxPin      (link.devTx),
    .rxValid    (rxValid),
    .rxByte     (rxByte),
    .rxFrameErr (rxFrameErr)
  );

  // ****************
  // next state
  // ****************
  always_comb begin
    s_nxt         = s_r;
    s_nxt.txGo    = 1'b0;
    s_nxt.rdata   = 32'h0000_0000;
    s_nxt.txBusyD = txBusy;
    s_nxt.eSync1  = link.errLine;
    s_nxt.eSync2  = s_r.eSync1;
    s_nxt.ePrev   = s_r.eSync2;
    // quiet time restarts while the device is held in reset
    if (s_r.devRst) begin
      s_nxt.quiet = 20'(QUIET_CYC);
    end else if (s_r.quiet != 20'h0_0000) begin
      s_nxt.quiet = s_r.quiet - 20'h0_0001;
    end
    ev              = '0;
    ev[IRQ_RX]      = rxValid;
    ev[IRQ_TXDONE]  = s_r.txBusyD & ~txBusy;
    ev[IRQ_FRAME]   = rxFrameErr;
    ev[IRQ_ERRRISE] = s_r.eSync2 & ~s_r.ePrev;
    if (rxValid) begin
      s_nxt.rxByte = rxByte;
      s_nxt.rxFull = 1'b1;
    end
    if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          s_nxt.devRst = wdata[CTRL_DEVRST];
          if (wdata[CTRL_DEVRST]) begin
            s_nxt.quiet = 20'(QUIET_CYC);
          end
        end
        REG_BAUD:  s_nxt.bitCyc = (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
        REG_TXD: begin
          if (s_r.quiet == 20'h0_0000 && !s_r.devRst && !txBusy && !s_r.txGo) begin
            s_nxt.txGo   = 1'b1;
            s_nxt.txByte = wdata[7:0];
          end
        end
        REG_ISTAT: s_nxt.iStat = s_r.iStat & ~wdata[IRQ_W-1:0];
        REG_IMASK: s_nxt.iMask = wdata[IRQ_W-1:0];
        default:   s_nxt.iMask = s_r.iMask;
      endcase
    end
    s_nxt.iStat = s_nxt.iStat | ev;                       // set wins over clear
    if (rd) begin
      unique case (addr)
        REG_CTRL:  s_nxt.rdata = {31'h0000_0000, s_r.devRst};
        REG_BAUD:  s_nxt.rdata = {16'h0000, s_r.bitCyc};
        REG_RXD: begin
          s_nxt.rdata  = {24'h00_0000, s_r.rxByte};
          s_nxt.rxFull = rxValid;
        end
        REG_STAT:  s_nxt.rdata = {28'h000_0000, s_r.eSync2, s_r.rxFull,
                                  (s_r.quiet != 20'h0_0000), txBusy | s_r.txGo};
        REG_ISTAT: s_nxt.rdata = {28'h000_0000, s_r.iStat};
        REG_IMASK: s_nxt.rdata = {28'h000_0000, s_r.iMask};
        default:   s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    s_nxt.irq = |(s_nxt.iStat & s_nxt.iMask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{bitCyc: 16'(BIT_CYC), quiet: 20'(QUIET_CYC), iStat: IRQ_RST,
               iMask: IRQ_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata        = s_r.rdata;
  assign irq          = s_r.irq;
  assign link.devRstN = ~s_r.devRst;
endmodule : msp_host
`default_nettype wire

// file: design/msp_link_if.sv
// serial link between host and device, with shared error line and reset pin
`timescale 1ns/10ps
`default_nettype none
interface msp_link_if;
  logic hostTx;
  logic devTx;
  logic devErr;
  logic extErr;
  logic errLine;
  logic devRstN;
  // wired-or error line; extErr stands for other devices on it
  assign errLine = devErr | extErr;
  modport dev (input hostTx, input errLine, input devRstN, output devTx, output devErr);
  modport host (output hostTx, output devRstN, input devTx, input errLine);
endinterface : msp_link_if
`default_nettype wire

// file: design/msp_pkg.sv
// constants shared by both ends of the motor serial port
//
// Summary of operation
// - idle line is held high
// - one low start bit opens each byte
// - eight data bits follow, LSB first
// - format is 8-N-1 on both ends
// - stop bit holds line high one bit
// - each end times bits from own clock
// - device bit rate configurable, default 9600
// - non-inverted levels: low is 0, high is 1
// - error output high while an error stops motor
// - high error line is error unless disabled
// - device answers error query with error bits
// - short commands carry no number, all execute
// - addressed commands execute on matching number only
// - hard reset de-energizes motor outputs
// - host waits 10 ms after reset to send
// - receive on rx input, reply on tx output
package msp_pkg;
  // ****************
  // timing
  // ****************
  localparam int CLK_HZ        = 100_000_000;
  localparam int BAUD_DEF      = 9600;
  localparam int BIT_CYC_DEF   = (CLK_HZ + BAUD_DEF / 2) / BAUD_DEF;
  localparam int QUIET_MS      = 10;
  localparam int QUIET_CYC_DEF = QUIET_MS * (CLK_HZ / 1000);
  localparam int BITS_PER_CHAR = 10;
  localparam int DATA_BITS     = 8;
  // ****************
  // command bytes
  // ****************
  localparam logic [7:0] ADDR_PREFIX  = 8'hAA;
  localparam logic [6:0] CMD_GET_ERR  = 7'h41;
  localparam logic [6:0] CMD_ENERGIZE = 7'h05;
  localparam logic [6:0] CMD_DEENERGY = 7'h06;
  localparam logic [6:0] DEVNUM_DEF   = 7'd14;
  // ****************
  // device settings port
  // ****************
  localparam logic [1:0] CFG_BAUD    = 2'd0;
  localparam logic [1:0] CFG_DEVNUM  = 2'd1;
  localparam logic [1:0] CFG_FLAGS   = 2'd2;
  localparam int         FLAG_IGNERR = 0;
  // ****************
  // host registers
  // ****************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_BAUD  = 8'h04;
  localparam logic [7:0] REG_TXD   = 8'h08;
  localparam logic [7:0] REG_RXD   = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_ISTAT = 8'h14;
  localparam logic [7:0] REG_IMASK = 8'h18;
  localparam int CTRL_DEVRST = 0;
  localparam int ST_TXBUSY   = 0;
  localparam int ST_QUIET    = 1;
  localparam int ST_RXFULL   = 2;
  localparam int ST_ERRLINE  = 3;
  localparam int IRQ_RX      = 0;
  localparam int IRQ_TXDONE  = 1;
  localparam int IRQ_FRAME   = 2;
  localparam int IRQ_ERRRISE = 3;
  localparam int IRQ_W       = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
endpackage : msp_pkg

// file: design/msp_uart.sv
// 8-N-1 transmitter and receiver timed from the local clock
`timescale 1ns/10ps
`default_nettype none
module msp_uart
  import msp_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // bit timing
  input  wire logic [15:0] bitCyc,
  // transmit side
  input  wire logic        txGo,
  input  wire logic [7:0]  txByte,
  output logic             txBusy,
  output logic             txLine,
  // receive side
  input  wire logic        rxPin,
  output logic             rxValid,
  output logic [7:0]       rxByte,
  output logic             rxFrameErr
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } msp_rxst_t;
  typedef struct packed {
    logic        txBusy;
    logic        txLine;
    logic [15:0] txCnt;
    logic [3:0]  txIdx;
    logic [9:0]  txSh;
    logic        sync1;
    logic        sync2;
    logic        prev;
    msp_rxst_t   rxSt;
    logic [15:0] rxCnt;
    logic [2:0]  rxIdx;
    logic [7:0]  rxSh;
    logic        rxValid;
    logic        rxFrameErr;
  } msp_uart_t;
  msp_uart_t s_r, s_nxt;

  // ****************
  // next state
  // ****************
  always_comb begin
    s_nxt            = s_r;
    s_nxt.rxValid    = 1'b0;
    s_nxt.rxFrameErr = 1'b0;
    // transmitter
    if (!s_r.txBusy) begin
      s_nxt.txLine = 1'b1;
      if (txGo) begin
        s_nxt.txBusy = 1'b1;
        s_nxt.txSh   = {1'b1, txByte, 1'b0};
        s_nxt.txLine = 1'b0;
        s_nxt.txCnt  = 16'h0000;
        s_nxt.txIdx  = 4'h0;
      end
    end else if (s_r.txCnt == bitCyc - 16'h0001) begin
      s_nxt.txCnt = 16'h0000;
      if (s_r.txIdx == 4'(BITS_PER_CHAR - 1)) begin
        s_nxt.txBusy = 1'b0;                                // stop bit served
      end else begin
        s_nxt.txIdx  = s_r.txIdx + 4'h1;
        s_nxt.txSh   = {1'b1, s_r.txSh[9:1]};
        s_nxt.txLine = s_r.txSh[1];
      end
    end else begin
      s_nxt.txCnt = s_r.txCnt + 16'h0001;
    end
    // receiver, pin passes two flops first
    s_nxt.sync1 = rxPin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    s_nxt.rxCnt = s_r.rxCnt + 16'h0001;
    unique case (s_r.rxSt)
      RX_IDLE: begin
        s_nxt.rxCnt = 16'h0000;
        if (s_r.prev && !s_r.sync2) begin
          s_nxt.rxSt = RX_START;
        end
      end
      RX_START: begin
        if (s_r.rxCnt == {1'b0, bitCyc[15:1]}) begin
          s_nxt.rxCnt = 16'h0000;
          s_nxt.rxIdx = 3'h0;
          s_nxt.rxSt  = s_r.sync2 ? RX_IDLE : RX_DATA;      // glitch rejected
        end
      end
      RX_DATA: begin
        if (s_r.rxCnt == bitCyc - 16'h0001) begin
          s_nxt.rxCnt = 16'h0000;
          s_nxt.rxSh  = {s_r.sync2, s_r.rxSh[7:1]};
          s_nxt.rxIdx = s_r.rxIdx + 3'h1;
          if (s_r.rxIdx == 3'(DATA_BITS - 1)) begin
            s_nxt.rxSt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (s_r.rxCnt == bitCyc - 16'h0001) begin
          s_nxt.rxSt       = RX_IDLE;
          s_nxt.rxValid    = s_r.sync2;
          s_nxt.rxFrameErr = !s_r.sync2;
        end
      end
      default: s_nxt.rxSt = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{txLine: 1'b1, sync1: 1'b1, sync2: 1'b1, prev: 1'b1, rxSt: RX_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign txBusy     = s_r.txBusy;
  assign txLine     = s_r.txLine;
  assign rxValid    = s_r.rxValid;
  assign rxByte     = s_r.rxSh;
  assign rxFrameErr = s_r.rxFrameErr;
endmodule : msp_uart
`default_nettype wire

// file: verif/motor_ctrl_serial_port_tb.sv
// self-checking bench joining host end and device end
`timescale 1ns/10ps
`default_nettype none
module motor_ctrl_serial_port_tb;
  import msp_pkg::*;
  localparam int BC = 16;
  localparam int QC = 200;
  logic        core_clk, nrst, wr, rd, irq, cfgWr, cmdStb, motorEn;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  cfgSel;
  logic [15:0] cfgData;
  logic [5:0]  coreErr;
  logic [6:0]  cmdCode, cmdArg;
  int          num_errors, checks, stbCnt, bitC;
  msp_link_if i_msp_link_if ();
  msp_host #(.BIT_CYC(BC), .QUIET_CYC(QC)) i_msp_host (.core_clk(core_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .link(i_msp_link_if.host));
  msp_device #(.BIT_CYC(BC)) i_msp_device (.core_clk(core_clk), .nrst(nrst),
    .link(i_msp_link_if.dev), .cfgWr(cfgWr), .cfgSel(cfgSel), .cfgData(cfgData),
    .coreErr(coreErr), .cmdStb(cmdStb), .cmdCode(cmdCode), .cmdArg(cmdArg), .motorEn(motorEn));
  msp_asserts #(.BIT_CYC(BC), .QUIET_CYC(QC)) i_msp_asserts (.core_clk(core_clk), .nrst(nrst),
    .hostTx(i_msp_link_if.hostTx), .devTx(i_msp_link_if.devTx), .devErr(i_msp_link_if.devErr),
    .extErr(i_msp_link_if.extErr), .devRstN(i_msp_link_if.devRstN));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (cmdStb === 1'b1) stbCnt++;
  // ****************
  // helpers
  // ****************
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic tmo(input string nm);
    $display("[ERR] %s expected done seen timeout", nm);
    num_errors++;
    final_report();
  endtask : tmo
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rdReg
  task automatic pollReg(input logic [7:0] a, input int b, input logic v, input string nm);
    logic [31:0] d;
    int k;
    k = 0;
    rdReg(a, d);
    while (d[b] !== v && k < 2000) begin
      rdReg(a, d);
      k++;
    end
    if (k >= 2000) tmo(nm);
  endtask : pollReg
  task automatic cfg(input logic [1:0] s, input logic [15:0] d);
    @(posedge core_clk);
    cfgWr   <= 1'b1;
    cfgSel  <= s;
    cfgData <= d;
    @(posedge core_clk);
    cfgWr <= 1'b0;
    repeat (10) @(negedge core_clk);
  endtask : cfg
  function automatic logic lineOf(input logic sel);
    return sel ? i_msp_link_if.devTx : i_msp_link_if.hostTx;
  endfunction : lineOf
  task automatic capt(input logic sel, input logic [7:0] b);
    logic [7:0] got;
    int k;
    k = 0;
    while (lineOf(sel) !== 1'b0 && k < 40 * bitC) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 40 * bitC) tmo("start bit");
    repeat (bitC / 2) @(negedge core_clk);
    chk("start bit", 0, lineOf(sel));
    for (int i = 0; i < 8; i++) begin
      repeat (bitC) @(negedge core_clk);
      got[i] = lineOf(sel);
    end
    chk("data bits", b, got);
    repeat (bitC) @(negedge core_clk);
    chk("stop bit", 1, lineOf(sel));
  endtask : capt
  task automatic sendList(input logic [7:0] q [$]);
    foreach (q[i]) begin
      wrReg(REG_TXD, {24'h00_0000, q[i]});
      capt(1'b0, q[i]);
      pollReg(REG_STAT, ST_TXBUSY, 1'b0, "tx busy");
    end
  endtask : sendList
  task automatic expCmd(input int n0, input int dn, input logic [6:0] c, input logic [6:0] a);
    repeat (2 * bitC) @(negedge core_clk);
    chk("command count", dn, stbCnt - n0);
    if (dn > 0) begin
      chk("command code", c, cmdCode);
      chk("command arg", a, cmdArg);
    end
  endtask : expCmd
  // ****************
  // scenarios
  // ****************
  task automatic t_quiet;
    logic [31:0] d;
    rdReg(REG_STAT, d);
    chk("quiet flag", 1, d[ST_QUIET]);
    wrReg(REG_TXD, 32'h0000_0085);
    repeat (20) @(negedge core_clk);
    chk("idle line", 1, i_msp_link_if.hostTx);
    rdReg(8'h20, d);
    chk("unmapped read", 0, d);
    rdReg(REG_IMASK, d);
    chk("mask reset", 0, d);
    pollReg(REG_STAT, ST_QUIET, 1'b0, "quiet end");
  endtask : t_quiet
  task automatic t_cmds;
    int n0;
    n0 = stbCnt;
    sendList('{8'h85, 8'h5A});
    expCmd(n0, 1, 7'h05, 7'h5A);
    chk("motor on", 1, motorEn);
    n0 = stbCnt;
    sendList('{8'hAA, 8'h0F, 8'h06, 8'h33});
    expCmd(n0, 0, 7'h06, 7'h33);
    chk("motor kept", 1, motorEn);
    n0 = stbCnt;
    sendList('{8'hAA, 8'h0E, 8'h06, 8'h33});
    expCmd(n0, 1, 7'h06, 7'h33);
    chk("motor off", 0, motorEn);
  endtask : t_cmds
  task automatic t_baud;
    logic [31:0] d;
    int n0;
    cfg(CFG_BAUD, 16'h0020);
    wrReg(REG_BAUD, 32'h0000_0020);
    rdReg(REG_BAUD, d);
    chk("baud reg", 32'h0000_0020, d);
    bitC = 32;
    n0 = stbCnt;
    sendList('{8'h85, 8'h55});
    expCmd(n0, 1, 7'h05, 7'h55);
    cfg(CFG_BAUD, 16'h0010);
    wrReg(REG_BAUD, 32'h0000_0010);
    bitC = BC;
  endtask : t_baud
  task automatic t_errq;
    logic [31:0] d;
    wrReg(REG_IMASK, 32'h0000_0001 << IRQ_RX);
    coreErr <= 6'h05;
    repeat (10) @(negedge core_clk);
    chk("error out", 1, i_msp_link_if.devErr);
    chk("motor stopped", 0, motorEn);
    sendList('{8'hC1});
    wrReg(REG_TXD, 32'h0000_0000);
    capt(1'b0, 8'h00);
    capt(1'b1, 8'hC5);
    pollReg(REG_STAT, ST_RXFULL, 1'b1, "reply");
    chk("irq raised", 1, irq);
    rdReg(REG_RXD, d);
    chk("reply byte", 32'h0000_00C5, d);
    wrReg(REG_IMASK, 32'h0000_0000);
    repeat (3) @(negedge core_clk);
    chk("irq masked", 0, irq);
    wrReg(REG_IMASK, 32'h0000_0001 << IRQ_RX);
    repeat (3) @(negedge core_clk);
    chk("irq unmasked", 1, irq);
    wrReg(REG_ISTAT, 32'h0000_000F);
    repeat (3) @(negedge core_clk);
    chk("irq cleared", 0, irq);
  endtask : t_errq
  task automatic t_errline;
    @(posedge core_clk);
    coreErr <= 6'h00;
    cfg(CFG_FLAGS, 16'h0001 << FLAG_IGNERR);
    chk("error ignored", 0, i_msp_link_if.devErr);
    cfg(CFG_FLAGS, 16'h0000);
    @(posedge core_clk);
    i_msp_link_if.extErr <= 1'b1;
    repeat (10) @(negedge core_clk);
    chk("line error", 1, i_msp_link_if.devErr);
    cfg(CFG_FLAGS, 16'h0001 << FLAG_IGNERR);
    @(posedge core_clk);
    i_msp_link_if.extErr <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk("line error gone", 0, i_msp_link_if.devErr);
    cfg(CFG_FLAGS, 16'h0000);
  endtask : t_errline
  // host sends at double bit time so the device reads a low stop bit
  task automatic t_frame;
    logic [31:0] d;
    int n0;
    n0 = stbCnt;
    sendList('{8'h85});
    wrReg(REG_BAUD, 32'h0000_0020);
    bitC = 32;
    sendList('{8'hF7});
    wrReg(REG_BAUD, 32'h0000_0010);
    bitC = BC;
    sendList('{8'h33});
    expCmd(n0, 0, 7'h05, 7'h33);
    rdReg(REG_ISTAT, d);
    chk("tx done flag", 1, d[IRQ_TXDONE]);
  endtask : t_frame
  task automatic t_devrst;
    logic [31:0] d;
    int n0;
    sendList('{8'h85, 8'h00});
    repeat (2 * bitC) @(negedge core_clk);
    chk("motor on", 1, motorEn);
    wrReg(REG_CTRL, 32'h0000_0001);
    @(negedge core_clk);
    chk("reset pin", 0, i_msp_link_if.devRstN);
    chk("motor dropped", 0, motorEn);
    wrReg(REG_CTRL, 32'h0000_0000);
    rdReg(REG_STAT, d);
    chk("quiet again", 1, d[ST_QUIET]);
    pollReg(REG_STAT, ST_QUIET, 1'b0, "quiet end");
    n0 = stbCnt;
    sendList('{8'hAA, 8'h0E, 8'h05, 8'h11});
    expCmd(n0, 1, 7'h05, 7'h11);
  endtask : t_devrst
  initial begin
    core_clk = 0; nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
    cfgWr = 0; cfgSel = 0; cfgData = 0; coreErr = 0;
    i_msp_link_if.extErr = 0;
    num_errors = 0; checks = 0; stbCnt = 0; bitC = BC;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    t_quiet();
    t_cmds();
    t_baud();
    t_errq();
    t_errline();
    t_frame();
    t_devrst();
    final_report();
  end
endmodule : motor_ctrl_serial_port_tb
`default_nettype wire

// file: verif/msp_asserts.sv
// checker for the link signals between host end and device end
`timescale 1ns/10ps
`default_nettype none
module msp_asserts #(
  parameter int BIT_CYC   = 16,
  parameter int QUIET_CYC = 200
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  input wire logic hostTx,
  input wire logic devTx,
  input wire logic devErr,
  input wire logic extErr,
  input wire logic devRstN
);
  // ****************
  // run length and quiet helpers
  // ****************
  logic [1:0] ln;
  logic [1:0] lnPrev_r;
  int         run_r [2];
  int         quiet_r;
  assign ln = {devTx, hostTx};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lnPrev_r <= 2'b11;
      run_r[0] <= 0;
      run_r[1] <= 0;
      quiet_r  <= 0;
    end else begin
      lnPrev_r <= ln;
      for (int i = 0; i < 2; i++) begin
        run_r[i] <= (ln[i] != lnPrev_r[i]) ? 1 : run_r[i] + 1;
      end
      quiet_r <= !devRstN ? 0 : (quiet_r < QUIET_CYC ? quiet_r + 1 : quiet_r);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ****************
  // properties
  // ****************
  sequence s_ext_rise;
    $rose(extErr) && !devErr && devRstN;
  endsequence
  sequence s_err_up;
    ##[1:8] devErr;
  endsequence
  property p_host_low;
    (!lnPrev_r[0] && ln[0]) |-> (run_r[0] % BIT_CYC == 0) && (run_r[0] <= 9 * BIT_CYC);
  endproperty
  property p_host_stop;
    (lnPrev_r[0] && !ln[0]) |-> run_r[0] >= BIT_CYC;
  endproperty
  property p_dev_low;
    (!lnPrev_r[1] && ln[1]) |-> (run_r[1] % BIT_CYC == 0) && (run_r[1] <= 9 * BIT_CYC);
  endproperty
  property p_dev_stop;
    (lnPrev_r[1] && !ln[1]) |-> run_r[1] >= BIT_CYC;
  endproperty
  property p_rst_tx;
    !devRstN |-> devTx;
  endproperty
  property p_rst_err;
    !devRstN |-> !devErr;
  endproperty
  property p_ext_err;
    s_ext_rise |-> s_err_up;
  endproperty
  property p_quiet;
    $fell(hostTx) |-> quiet_r >= QUIET_CYC;
  endproperty
  a_host_low:  assert property (p_host_low)
    else $error("host frame low run bad");
  a_host_stop: assert property (p_host_stop)
    else $error("host stop bit short");
  a_dev_low:   assert property (p_dev_low)
    else $error("device frame low run bad");
  a_dev_stop:  assert property (p_dev_stop)
    else $error("device stop bit short");
  a_rst_tx:    assert property (p_rst_tx)
    else $error("device line not idle in reset");
  a_rst_err:   assert property (p_rst_err)
    else $error("error output set in reset");
  a_ext_err:   assert property (p_ext_err)
    else $error("error line high not sensed");
  a_quiet:     assert property (p_quiet)
    else $error("host sent inside quiet time");
endmodule : msp_asserts
`default_nettype wire
